// ===== shared/xcr_pkg.sv
// Package: register map, field layout and types of the crosstalk calibration slice
package xcr_pkg;

  // ----------------------------------------
  // Bus widths
  // ----------------------------------------
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 24;

  // ----------------------------------------
  // Register offsets (register index on the control interface)
  // ----------------------------------------
  localparam logic [7:0] XTALK_TX2_LOW_INPHASE_AND_COEFF_OFS = 8'h37;
  localparam logic [7:0] XTALK_TX2_LOW_QUAD_AND_COEFF_OFS = 8'h38;
  localparam logic [7:0] XTALK_TX2_HIGH_INPHASE_AND_COEFF_OFS = 8'h39;
  localparam logic [7:0] XTALK_TX2_HIGH_QUAD_AND_SCALING_OFS = 8'h3a;
  localparam logic [7:0] INPHASE_READBACK_OFS = 8'h3b;
  localparam logic [7:0] QUADRATURE_READBACK_OFS = 8'h3c;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int unsigned COEFF_LSB = 16;
  localparam int unsigned COEFF_W = 8;
  localparam int unsigned XT_LSB = 0;
  localparam int unsigned XT_W = 16;
  localparam int unsigned TEMP_EN_BIT = 16;
  localparam int unsigned TEMP_SCALE_LSB = 17;
  localparam int unsigned SCALE_W = 3;
  localparam int unsigned AMB_SCALE_LSB = 20;
  localparam int unsigned RSVD_BIT = 23;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] COEFF_RST = 8'h00;
  localparam logic [15:0] XT_RST = 16'h0000;
  localparam logic TEMP_EN_RST = 1'b0;
  localparam logic [2:0] AMB_SCALE_RST = 3'h4;
  localparam logic [2:0] TEMP_SCALE_RST = 3'h5;
  localparam logic [23:0] READBACK_RST = 24'h000000;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef struct packed {
    logic wr_en;
    logic rd_en;
    logic [7:0] addr;
    logic [23:0] wdata;
  } xcr_req_type;

  typedef struct packed {
    logic [7:0] illum_temp_coeff_quad_ch0_low;
    logic [7:0] main_temp_coeff_inphase_ch0_low;
    logic [7:0] main_temp_coeff_quad_ch0_low;
    logic [15:0] ch2_low_inphase_xt;
    logic [15:0] ch2_low_quad_xt;
    logic [15:0] ch2_high_inphase_xt;
    logic [15:0] ch2_high_quad_xt;
    logic [2:0] ambient_coeff_scale;
    logic [2:0] temperature_coeff_scale;
    logic temp_correction_enable;
  } xcr_cfg_type;

  typedef struct packed {
    logic [23:0] inphase_readback_value;
    logic [23:0] quad_readback_value;
  } xcr_iq_type;

  typedef struct packed {
    xcr_cfg_type cfg;
    xcr_iq_type iq;
    logic [23:0] rdata;
    logic rvalid;
  } xcr_state_type;

endpackage

// ===== rtl/xcr_regs.sv
// Module: crosstalk calibration register slice, offsets 37h to 3Ch
`timescale 1ns/1ps
// Operation
// - 37h[23:16] illumination-sensor quad temp coefficient, ch0 low, RW, reset zero.
// - 37h[15:0] ch2 low-current in-phase crosstalk, RW, reset zero.
// - 38h[23:16] on-chip-sensor in-phase temp coefficient, ch0 low, RW, reset zero.
// - 38h[15:0] ch2 low-current quadrature crosstalk, RW, reset zero.
// - 39h[23:16] on-chip-sensor quad temp coefficient, ch0 low, RW, reset zero.
// - 39h[15:0] ch2 high-current in-phase crosstalk, RW, reset zero.
// - 3Ah[15:0] ch2 high-current quadrature crosstalk, RW, reset zero.
// - 3Ah bit 16 enables temperature crosstalk correction, reset zero.
// - 3Ah[22:20] ambient coefficient scale, RW, reset four.
// - 3Ah[19:17] temperature coefficient scale, RW, reset five.
// - 3Bh reads the 24-bit in-phase value sampled from iq_in.
// - 3Ch reads the 24-bit quadrature value sampled from iq_in the same way.
module xcr_regs
  import xcr_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire xcr_pkg::xcr_req_type req,
  input wire xcr_pkg::xcr_iq_type iq_in,
  output logic [xcr_pkg::DATA_W-1:0] rdata,
  output logic rvalid,
  output xcr_pkg::xcr_cfg_type cfg
);
  import xcr_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  xcr_state_type state_r;
  xcr_state_type state_nxt;

  function automatic logic [23:0] pack_reg(input logic [7:0] hi, input logic [15:0] lo);
    pack_reg = {hi, lo};
  endfunction

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    state_nxt = state_r;
    state_nxt.rvalid = 1'b0;
    // Readback values sampled from iq_in every cycle
    state_nxt.iq = iq_in;
    if (req.wr_en) begin
      case (req.addr)
        XTALK_TX2_LOW_INPHASE_AND_COEFF_OFS: begin
          state_nxt.cfg.illum_temp_coeff_quad_ch0_low =
            req.wdata[COEFF_LSB +: COEFF_W];
          state_nxt.cfg.ch2_low_inphase_xt = req.wdata[XT_LSB +: XT_W];
        end
        XTALK_TX2_LOW_QUAD_AND_COEFF_OFS: begin
          state_nxt.cfg.main_temp_coeff_inphase_ch0_low =
            req.wdata[COEFF_LSB +: COEFF_W];
          state_nxt.cfg.ch2_low_quad_xt = req.wdata[XT_LSB +: XT_W];
        end
        XTALK_TX2_HIGH_INPHASE_AND_COEFF_OFS: begin
          state_nxt.cfg.main_temp_coeff_quad_ch0_low =
            req.wdata[COEFF_LSB +: COEFF_W];
          state_nxt.cfg.ch2_high_inphase_xt = req.wdata[XT_LSB +: XT_W];
        end
        XTALK_TX2_HIGH_QUAD_AND_SCALING_OFS: begin
          state_nxt.cfg.ch2_high_quad_xt = req.wdata[XT_LSB +: XT_W];
          state_nxt.cfg.temp_correction_enable = req.wdata[TEMP_EN_BIT];
          state_nxt.cfg.ambient_coeff_scale = req.wdata[AMB_SCALE_LSB +: SCALE_W];
          state_nxt.cfg.temperature_coeff_scale =
            req.wdata[TEMP_SCALE_LSB +: SCALE_W];
          // Bit 23 is not stored, so it always reads zero
        end
        // Readback offsets and unmapped offsets fall here untouched
        default: begin
          state_nxt.cfg = state_r.cfg;
        end
      endcase
    end
    if (req.rd_en) begin
      state_nxt.rvalid = 1'b1;
      case (req.addr)
        XTALK_TX2_LOW_INPHASE_AND_COEFF_OFS: begin
          state_nxt.rdata = pack_reg(state_r.cfg.illum_temp_coeff_quad_ch0_low,
                                     state_r.cfg.ch2_low_inphase_xt);
        end
        XTALK_TX2_LOW_QUAD_AND_COEFF_OFS: begin
          state_nxt.rdata = pack_reg(state_r.cfg.main_temp_coeff_inphase_ch0_low,
                                     state_r.cfg.ch2_low_quad_xt);
        end
        XTALK_TX2_HIGH_INPHASE_AND_COEFF_OFS: begin
          state_nxt.rdata = pack_reg(state_r.cfg.main_temp_coeff_quad_ch0_low,
                                     state_r.cfg.ch2_high_inphase_xt);
        end
        XTALK_TX2_HIGH_QUAD_AND_SCALING_OFS: begin
          state_nxt.rdata = {1'b0, state_r.cfg.ambient_coeff_scale,
                             state_r.cfg.temperature_coeff_scale,
                             state_r.cfg.temp_correction_enable,
                             state_r.cfg.ch2_high_quad_xt};
        end
        INPHASE_READBACK_OFS: begin
          state_nxt.rdata = state_r.iq.inphase_readback_value;
        end
        QUADRATURE_READBACK_OFS: begin
          state_nxt.rdata = state_r.iq.quad_readback_value;
        end
        default: begin
          state_nxt.rdata = READBACK_RST;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge core_clk) begin
    if (rst) begin
      state_r.cfg.illum_temp_coeff_quad_ch0_low <= COEFF_RST;
      state_r.cfg.main_temp_coeff_inphase_ch0_low <= COEFF_RST;
      state_r.cfg.main_temp_coeff_quad_ch0_low <= COEFF_RST;
      state_r.cfg.ch2_low_inphase_xt <= XT_RST;
      state_r.cfg.ch2_low_quad_xt <= XT_RST;
      state_r.cfg.ch2_high_inphase_xt <= XT_RST;
      state_r.cfg.ch2_high_quad_xt <= XT_RST;
      state_r.cfg.ambient_coeff_scale <= AMB_SCALE_RST;
      state_r.cfg.temperature_coeff_scale <= TEMP_SCALE_RST;
      state_r.cfg.temp_correction_enable <= TEMP_EN_RST;
      state_r.iq.inphase_readback_value <= READBACK_RST;
      state_r.iq.quad_readback_value <= READBACK_RST;
      state_r.rdata <= READBACK_RST;
      state_r.rvalid <= 1'b0;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign rdata = state_r.rdata;
  assign rvalid = state_r.rvalid;
  // Live fields, so the next measurement sees a new value from the cycle after the write
  assign cfg = state_r.cfg;

endmodule // xcr_regs

// ===== sim/xcr_regs_properties.sv
// Checker: port-level properties of the crosstalk calibration register slice
`timescale 1ns/1ps
module xcr_regs_properties
  import xcr_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire xcr_pkg::xcr_req_type req,
  input wire xcr_pkg::xcr_iq_type iq_in,
  input wire logic [xcr_pkg::DATA_W-1:0] rdata,
  input wire logic rvalid,
  input wire xcr_pkg::xcr_cfg_type cfg
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // ----------------------------------------
  // Read path
  // ----------------------------------------
  AST_RVALID: assert property (rvalid == $past(req.rd_en))
    else $error("rvalid not one cycle after read strobe");
  AST_RDATA_HOLD: assert property (!req.rd_en |=> $stable(rdata))
    else $error("rdata changed without a read");
  AST_RD_IPHASE: assert property (req.rd_en && req.addr == 8'h3b
    |=> rdata == $past(iq_in.inphase_readback_value, 2)) else $error("in-phase readback wrong");
  AST_RD_QUAD: assert property (req.rd_en && req.addr == 8'h3c
    |=> rdata == $past(iq_in.quad_readback_value, 2)) else $error("quad readback wrong");
  AST_RD_SCALE: assert property (req.rd_en && req.addr == 8'h3a |=> rdata == {1'b0,
    $past(cfg.ambient_coeff_scale), $past(cfg.temperature_coeff_scale),
    $past(cfg.temp_correction_enable), $past(cfg.ch2_high_quad_xt)}) else $error("3a read wrong");
  // ----------------------------------------
  // Write path
  // ----------------------------------------
  AST_WR_37: assert property (req.wr_en && req.addr == 8'h37 |=>
    {cfg.illum_temp_coeff_quad_ch0_low, cfg.ch2_low_inphase_xt} == $past(req.wdata))
    else $error("write to 37 not stored");
  AST_WR_38: assert property (req.wr_en && req.addr == 8'h38 |=>
    {cfg.main_temp_coeff_inphase_ch0_low, cfg.ch2_low_quad_xt} == $past(req.wdata))
    else $error("write to 38 not stored");
  AST_WR_39: assert property (req.wr_en && req.addr == 8'h39 |=>
    {cfg.main_temp_coeff_quad_ch0_low, cfg.ch2_high_inphase_xt} == $past(req.wdata))
    else $error("write to 39 not stored");
  AST_WR_3A: assert property (req.wr_en && req.addr == 8'h3a |=>
    {cfg.ambient_coeff_scale, cfg.temperature_coeff_scale, cfg.temp_correction_enable,
    cfg.ch2_high_quad_xt} == $past(req.wdata[22:0])) else $error("write to 3a not stored");
  AST_CFG_HOLD: assert property (!(req.wr_en && req.addr inside {[8'h37:8'h3a]})
    |=> $stable(cfg)) else $error("cfg changed without a mapped write");
endmodule // xcr_regs_properties

bind xcr_regs xcr_regs_properties i_xcr_regs_properties (.core_clk(core_clk), .rst(rst),
  .req(req), .iq_in(iq_in), .rdata(rdata), .rvalid(rvalid), .cfg(cfg));

// ===== sim/tb_top.sv
// Testbench: register access sequences for the crosstalk calibration slice
`timescale 1ns/1ps
module tb_top;
  import xcr_pkg::*;
  logic core_clk = 1'b0;
  logic rst = 1'b1;
  xcr_req_type req = '0;
  xcr_iq_type iq_in = {24'h5a1234, 24'ha6edcb};
  logic [DATA_W-1:0] rdata;
  logic rvalid;
  xcr_cfg_type cfg;
  xcr_cfg_type ecfg;
  logic [23:0] ev;
  int miscompares = 0;
  int samples_checked = 0;
  logic [23:0] rv [6] = '{24'h0, 24'h0, 24'h0, 24'h4a0000, 24'h5a1234, 24'ha6edcb};
  xcr_regs i_xcr_regs (.core_clk(core_clk), .rst(rst), .req(req), .iq_in(iq_in),
    .rdata(rdata), .rvalid(rvalid), .cfg(cfg));
  initial begin
    forever #5 core_clk = ~core_clk;
  end
  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  task automatic chk(input logic [95:0] got, input logic [95:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Strobes stay up until the next task replaces req, so no double drive per step
  task automatic wr(input logic [7:0] a, input logic [23:0] v);
    req <= '{1'b1, 1'b0, a, v};
    @(posedge core_clk);
    #1;
  endtask
  task automatic rd(input logic [7:0] a, input logic [23:0] e);
    req <= '{1'b0, 1'b1, a, 24'h0};
    @(posedge core_clk);
    #1 chk({rvalid, rdata}, {1'b1, e});
  endtask
  task automatic conclude();
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    #20000 miscompares++;
    conclude();
  end
  initial begin
    repeat (20) @(posedge core_clk);
    #1 rst <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      rd(8'h37 + 8'(i), rv[i]);
    end
    rd(8'h36, 24'h0);
    rd(8'h3d, 24'h0);
    for (int i = 0; i < 4; i++) wr(8'h37 + 8'(i), 24'hffffff);
    chk(cfg, {1'b0, {95{1'b1}}});
    rd(8'h3a, 24'h7fffff);
    for (int i = 0; i < 4; i++) wr(8'h37 + 8'(i), {8'h37 + 8'(i), 8'h96, 8'h5c + 8'(i)});
    ecfg = {8'h37, 8'h38, 8'h39, 16'h965c, 16'h965d, 16'h965e, 16'h965f, 3'h3, 3'h5, 1'b0};
    chk(cfg, ecfg);
    for (int i = 0; i < 4; i++) begin
      ev = {8'h37 + 8'(i), 8'h96, 8'h5c + 8'(i)};
      rd(8'h37 + 8'(i), ev);
    end
    wr(8'h3b, 24'hffffff);
    wr(8'h3c, 24'hffffff);
    iq_in <= {24'h00c0de, 24'hfff001};
    wr(8'h3d, 24'hffffff);
    chk(cfg, ecfg);
    rd(8'h3b, 24'h00c0de);
    rd(8'h3c, 24'hfff001);
    wr(8'h3a, 24'h010000);
    chk(cfg.temp_correction_enable, 1'b1);
    req <= '{1'b1, 1'b1, 8'h37, 24'h0};
    @(posedge core_clk);
    #1 chk(rdata, 24'h37965c);
    rd(8'h37, 24'h0);
    req <= '0;
    rst <= 1'b1;
    @(posedge core_clk);
    #1 rst <= 1'b0;
    chk(cfg, {24'h0, 64'h0, 3'h4, 3'h5, 1'b0});
    rd(8'h3a, 24'h4a0000);
    req <= '0;
    @(posedge core_clk);
    conclude();
  end
endmodule // tb_top
